// ==== verilog/slm_pkg.sv ====
package slm_pkg;
    // ****************************************
    // lane mapping modes handled here
    // ****************************************
    localparam logic [3:0] MODE_8BIT_64B = 4'hC;
    localparam logic [3:0] MODE_9BIT_8B10B = 4'hD;
    localparam logic [3:0] MODE_9BIT_QUAD = 4'hE;
    localparam logic [3:0] MODE_9BIT_64B = 4'hF;
    // ****************************************
    // variants and test selections
    // ****************************************
    localparam logic [1:0] VAR_SINGLE = 2'h0;
    localparam logic [1:0] VAR_DUAL = 2'h1;
    localparam logic [1:0] VAR_QUAD = 2'h2;
    localparam logic [1:0] TEST_OFF = 2'h0;
    localparam logic [1:0] TEST_RAMP = 2'h1;
    localparam logic [1:0] TEST_CLOCK = 2'h2;
    localparam logic [1:0] SYNC_CRC12 = 2'h0;
    localparam logic [1:0] SYNC_FEC = 2'h1;
    // ****************************************
    // geometry and reset values
    // ****************************************
    localparam int LANES = 8;
    localparam int OCTETS = 5;
    localparam int SAMPLES = 16;
    localparam logic [39:0] LANE_RESET = 40'h00_0000_0000;
    localparam logic [7:0] RAMP_STEP = 8'h01;
    localparam logic [15:0] CLOCK_WORD = 16'hFF00;
    localparam logic [7:0] LANES_ALL = 8'hFF;
    localparam logic [7:0] LANES_LOW = 8'h0F;
    localparam logic [7:0] LANES_LOW2 = 8'h03;
    localparam logic [7:0] LANES_NONE = 8'h00;
endpackage

// ==== verilog/slm_lane_if.sv ====
`timescale 1ns/1ns
// carries packed lane words from the packer to the output stage
interface slm_lane_if;
    logic [39:0] word [8];
    logic [7:0] used;
    logic [2:0] octets;
    modport src (output word, output used, output octets);
    modport dst (input word, input used, input octets);
endinterface

// ==== verilog/slm_packer.sv ====
`timescale 1ns/1ns
// combinational sample packer; lane word octet 0 sits in bits 39:32
module slm_packer
(
    // mode
    input wire logic [3:0] laneMappingMode,
    input wire logic [1:0] variant,
    // samples, channel-major: chA, chB, chC, chD
    input wire logic [8:0] sampleA [16],
    input wire logic [8:0] sampleB [16],
    input wire logic [8:0] sampleC [16],
    input wire logic [8:0] sampleD [16],
    // packed result
    slm_lane_if.src lanes
);
    // ****************************************
    // per-lane packing
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_lane
            // per-lane packing, one always_comb per lane
            always_comb
            begin
                lanes.word[gi] = slm_pkg::LANE_RESET;
                case (laneMappingMode)
                    slm_pkg::MODE_8BIT_64B:
                    begin
                        // upper 8 bits of the sample as one octet
                        if (gi < 4)
                            lanes.word[gi][39:32] = sampleA[gi][8:1];
                        else
                            lanes.word[gi][39:32] = sampleB[gi-4][8:1];
                    end
                    slm_pkg::MODE_9BIT_8B10B:
                    begin
                        // four 9+1 bit fields fill five octets
                        if (gi < 4)
                            lanes.word[gi] = {sampleA[gi], 1'b0, sampleA[gi+4], 1'b0,
                                sampleA[gi+8], 1'b0, sampleA[gi+12], 1'b0};
                        else
                            lanes.word[gi] = {sampleB[gi-4], 1'b0, sampleB[gi], 1'b0,
                                sampleB[gi+4], 1'b0, sampleB[gi+8], 1'b0};
                    end
                    slm_pkg::MODE_9BIT_QUAD:
                    begin
                        // pairs of lanes per channel
                        if (gi < 2)
                            lanes.word[gi][39:16] = {sampleA[gi], 3'h0, sampleA[gi+2], 3'h0};
                        else if (gi < 4)
                            lanes.word[gi][39:16] = {sampleB[gi-2], 3'h0, sampleB[gi], 3'h0};
                        else if (gi < 6)
                            lanes.word[gi][39:16] = {sampleC[gi-4], 3'h0,
                                sampleC[gi-2], 3'h0};
                        else
                            lanes.word[gi][39:16] = {sampleD[gi-6], 3'h0,
                                sampleD[gi-4], 3'h0};
                    end
                    slm_pkg::MODE_9BIT_64B:
                    begin
                        // samples k and k+4 per lane
                        if (gi < 4)
                            lanes.word[gi][39:16] = {sampleA[gi], 3'h0, sampleA[gi+4], 3'h0};
                        else
                            lanes.word[gi][39:16] = {sampleB[gi-4], 3'h0,
                                sampleB[gi], 3'h0};
                    end
                    default:
                        lanes.word[gi] = slm_pkg::LANE_RESET;
                endcase
            end
        end
    endgenerate

    // ****************************************
    // lanes in use per mode and variant
    // ****************************************
    // fewer channels leave the upper lanes dark
    always_comb
    begin
        lanes.used = slm_pkg::LANES_NONE;
        lanes.octets = 3'h3;
        case (laneMappingMode)
            slm_pkg::MODE_8BIT_64B, slm_pkg::MODE_9BIT_8B10B, slm_pkg::MODE_9BIT_64B:
            begin
                lanes.used = (variant == slm_pkg::VAR_SINGLE) ? slm_pkg::LANES_LOW
                    : slm_pkg::LANES_ALL;
                lanes.octets = (laneMappingMode == slm_pkg::MODE_8BIT_64B) ? 3'h1
                    : (laneMappingMode == slm_pkg::MODE_9BIT_8B10B) ? 3'h5 : 3'h3;
            end
            slm_pkg::MODE_9BIT_QUAD:
            begin
                lanes.used = (variant == slm_pkg::VAR_QUAD) ? slm_pkg::LANES_ALL
                    : (variant == slm_pkg::VAR_DUAL) ? slm_pkg::LANES_LOW
                    : slm_pkg::LANES_LOW2;
            end
            default:
                lanes.used = slm_pkg::LANES_NONE;
        endcase
    end
endmodule

// ==== verilog/slm_lane_mapper.sv ====
`timescale 1ns/1ns
// Operation
// - mode 12: one 8-bit octet per lane, chA lanes 0-3, chB lanes 4-7.
// - mode 13 8b10b: four 9-bit samples plus zero bit in five octets.
// - mode 14: two samples per lane, three zero pad bits, four channels.
// - mode 15: lane k carries samples k and k+4, padded to three octets.
// - sync header offers CRC-12; no CRC-3 variant.
// - FEC offered as alternative sync header mode.
// - alternate lanes allowed only in modes using four lanes or fewer.
// - group select 0 drives D3-D0, 1 drives same data on D7-D4.
// - only one lane group driven in modes using four lanes or fewer.
// - power-down input high disables all serial output drivers.
// - mode setting can also force power-down.
// - configuration held intact through power-down.
// - test modes inject known patterns into output path.
// - lanes powered and rated by mapping mode whatever the test mode.
module slm_lane_mapper
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration
    input wire logic [3:0] laneMappingMode,
    input wire logic [1:0] variant,
    input wire logic laneGroupSelect,
    input wire logic [1:0] syncHeaderMode,
    input wire logic [1:0] serializerTestSelect,
    input wire logic modePowerDown,
    input wire logic powerDownInput,
    input wire logic sampleValid,
    // samples
    input wire logic [8:0] sampleA [16],
    input wire logic [8:0] sampleB [16],
    input wire logic [8:0] sampleC [16],
    input wire logic [8:0] sampleD [16],
    // lanes
    output logic [39:0] laneData [8],
    output logic [7:0] laneEnable,
    output logic [2:0] laneOctets,
    output logic syncCrc12,
    output logic syncFec,
    output logic altRefused,
    output logic poweredDown
);
    slm_lane_if lanes ();

    logic [39:0] laneData_r [8];
    logic [39:0] laneData_nxt [8];
    logic [7:0] laneEnable_r;
    logic [7:0] laneEnable_nxt;
    logic [2:0] laneOctets_r;
    logic [2:0] laneOctets_nxt;
    logic [7:0] ramp_r;
    logic [7:0] ramp_nxt;
    logic [15:0] clkPat_r;
    logic [15:0] clkPat_nxt;
    logic pd;
    logic altOk;
    logic [7:0] sel;

    // ****************************************
    // packing
    // ****************************************
    slm_packer i_slm_packer
    (
        .laneMappingMode(laneMappingMode),
        .variant(variant),
        .sampleA(sampleA),
        .sampleB(sampleB),
        .sampleC(sampleC),
        .sampleD(sampleD),
        .lanes(lanes.src)
    );

    // ****************************************
    // power-down and lane group choice
    // ****************************************
    // pin or mode may power down; config inputs untouched
    assign pd = powerDownInput | modePowerDown;
    // alternate set only when mode fits in the low four lanes
    assign altOk = (lanes.used[7:4] == 4'h0);
    assign altRefused = laneGroupSelect & ~altOk;
    assign poweredDown = pd;
    // crc-3 is simply not offered
    assign syncCrc12 = (syncHeaderMode == slm_pkg::SYNC_CRC12) & ~lanes.octets[2];
    assign syncFec = (syncHeaderMode == slm_pkg::SYNC_FEC) & ~lanes.octets[2];

    // one group only: the low mask moves up, never duplicated
    always_comb
    begin
        sel = lanes.used;
        if (laneGroupSelect && altOk)
            sel = {lanes.used[3:0], 4'h0};
    end

    // ****************************************
    // output staging
    // ****************************************
    // next values for lanes and test generators
    always_comb
    begin
        ramp_nxt = ramp_r + slm_pkg::RAMP_STEP;
        clkPat_nxt = {clkPat_r[14:0], clkPat_r[15]};
        // lane count and rate follow mode, not test
        laneEnable_nxt = pd ? slm_pkg::LANES_NONE : sel;
        laneOctets_nxt = lanes.octets;
        for (int i = 0; i < 8; i++)
        begin
            laneData_nxt[i] = slm_pkg::LANE_RESET;
        end
        for (int i = 0; i < 8; i++)
        begin
            if (!pd && sel[i])
            begin
                // known patterns replace samples
                case (serializerTestSelect)
                    slm_pkg::TEST_RAMP:
                        laneData_nxt[i] = {5{ramp_r}};
                    slm_pkg::TEST_CLOCK:
                        laneData_nxt[i] = {clkPat_r, clkPat_r, clkPat_r[15:8]};
                    default:
                        laneData_nxt[i] = (laneGroupSelect && altOk) ?
                            lanes.word[(i + 4) % 8] : lanes.word[i];
                endcase
            end
        end
        if (!sampleValid && serializerTestSelect == slm_pkg::TEST_OFF)
        begin
            for (int i = 0; i < 8; i++)
            begin
                laneData_nxt[i] = laneData_r[i];
            end
        end
    end

    // register stage
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 8; i++)
            begin
                laneData_r[i] <= slm_pkg::LANE_RESET;
            end
            laneEnable_r <= slm_pkg::LANES_NONE;
            laneOctets_r <= 3'h0;
            ramp_r <= 8'h00;
            clkPat_r <= slm_pkg::CLOCK_WORD;
        end
        else
        begin
            laneData_r <= laneData_nxt;
            laneEnable_r <= laneEnable_nxt;
            laneOctets_r <= laneOctets_nxt;
            ramp_r <= ramp_nxt;
            clkPat_r <= clkPat_nxt;
        end
    end

    assign laneData = laneData_r;
    assign laneEnable = laneEnable_r;
    assign laneOctets = laneOctets_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_pd_off;
        @(posedge core_clk) disable iff (rst)
        powerDownInput |=> (laneEnable == 8'h00);
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("lanes on in power-down");

    property p_mode_pd;
        @(posedge core_clk) disable iff (rst)
        modePowerDown |=> (laneEnable == 8'h00);
    endproperty
    a_mode_pd: assert property (p_mode_pd) else $error("mode power-down ignored");

    property p_one_group;
        @(posedge core_clk) disable iff (rst)
        !((|laneEnable[3:0]) && (|laneEnable[7:4]) && $past(laneGroupSelect && altOk));
    endproperty
    a_one_group: assert property (p_one_group) else $error("both groups driven");

    property p_alt;
        @(posedge core_clk) disable iff (rst)
        (laneGroupSelect && altOk && !pd) |=> (laneEnable[3:0] == 4'h0);
    endproperty
    a_alt: assert property (p_alt) else $error("default lanes on in alternate");

    property p_alt_refuse;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_8BIT_64B && variant == slm_pkg::VAR_DUAL)
        |-> altRefused == laneGroupSelect;
    endproperty
    a_alt_refuse: assert property (p_alt_refuse) else $error("alt allowed on 8 lanes");

    property p_m12;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_8BIT_64B && !pd && !laneGroupSelect && sampleValid
         && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[1][39:32] == $past(sampleA[1][8:1]);
    endproperty
    a_m12: assert property (p_m12) else $error("mode 12 lane 1 wrong");

    property p_m12_b;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_8BIT_64B && !pd && !laneGroupSelect && sampleValid
         && variant == slm_pkg::VAR_DUAL && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[4][39:32] == $past(sampleB[0][8:1]);
    endproperty
    a_m12_b: assert property (p_m12_b) else $error("mode 12 lane 4 wrong");

    property p_m13;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_8B10B && !pd && !laneGroupSelect && sampleValid
         && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[2][19:10] == {$past(sampleA[10]), 1'b0};
    endproperty
    a_m13: assert property (p_m13) else $error("mode 13 lane 2 wrong");

    property p_m13_b;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_8B10B && !pd && !laneGroupSelect && sampleValid
         && variant == slm_pkg::VAR_DUAL && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[5][39:30] == {$past(sampleB[1]), 1'b0};
    endproperty
    a_m13_b: assert property (p_m13_b) else $error("mode 13 lane 5 wrong");

    property p_m14;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_QUAD && !pd && !laneGroupSelect && sampleValid
         && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[1][27:16] == {$past(sampleA[3]), 3'h0};
    endproperty
    a_m14: assert property (p_m14) else $error("mode 14 lane 1 wrong");

    property p_m14_c;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_QUAD && !pd && !laneGroupSelect && sampleValid
         && variant == slm_pkg::VAR_QUAD && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[4][39:28] == {$past(sampleC[0]), 3'h0};
    endproperty
    a_m14_c: assert property (p_m14_c) else $error("mode 14 lane 4 wrong");

    property p_m15;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_64B && !pd && !laneGroupSelect && sampleValid
         && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[3][27:16] == {$past(sampleA[7]), 3'h0};
    endproperty
    a_m15: assert property (p_m15) else $error("mode 15 lane 3 wrong");

    property p_m15_b;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_64B && !pd && !laneGroupSelect && sampleValid
         && variant == slm_pkg::VAR_DUAL && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[6][39:28] == {$past(sampleB[2]), 3'h0};
    endproperty
    a_m15_b: assert property (p_m15_b) else $error("mode 15 lane 6 wrong");

    // alternate lanes carry the default lane data shifted up by four
    property p_alt_data;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_64B && !pd && laneGroupSelect && altOk
         && sampleValid && serializerTestSelect == slm_pkg::TEST_OFF)
        |=> laneData[4][39:28] == {$past(sampleA[0]), 3'h0};
    endproperty
    a_alt_data: assert property (p_alt_data) else $error("alternate lane data wrong");

    property p_rate;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_8B10B) |=> laneOctets == 3'h5;
    endproperty
    a_rate: assert property (p_rate) else $error("lane rate not from mode");

    property p_sync_none;
        @(posedge core_clk) disable iff (rst)
        (laneMappingMode == slm_pkg::MODE_9BIT_8B10B) |-> !syncCrc12 && !syncFec;
    endproperty
    a_sync_none: assert property (p_sync_none) else $error("sync header in 8b10b");

    property p_fec;
        @(posedge core_clk) disable iff (rst)
        (syncHeaderMode == slm_pkg::SYNC_FEC && laneMappingMode == slm_pkg::MODE_9BIT_64B)
        |-> syncFec && !syncCrc12;
    endproperty
    a_fec: assert property (p_fec) else $error("fec not selected");

    property p_clock;
        @(posedge core_clk) disable iff (rst)
        (serializerTestSelect == slm_pkg::TEST_CLOCK && !pd && sel[0])
        |=> $countones(laneData[0][39:24]) == 8;
    endproperty
    a_clock: assert property (p_clock) else $error("clock pattern wrong");

    property p_single;
        @(posedge core_clk) disable iff (rst)
        (variant == slm_pkg::VAR_SINGLE && !laneGroupSelect) |=> laneEnable[7:4] == 4'h0;
    endproperty
    a_single: assert property (p_single) else $error("absent lanes driven");

    // ramp selected on a live lane
    sequence s_ramp_on;
        serializerTestSelect == slm_pkg::TEST_RAMP && !pd && sel[0];
    endsequence

    property p_ramp;
        @(posedge core_clk) disable iff (rst)
        s_ramp_on ##1 s_ramp_on
        |=> laneData[0][7:0] == $past(laneData[0][7:0]) + 8'h01;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp not stepping");
endmodule

// ==== testbench/slm_rx_model.sv ====
`timescale 1ns/1ns
// receiver stand-in: drops lane data until stale pipeline samples have flushed
module slm_rx_model
#(
    parameter int FLUSH = 6
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // lanes from the device
    input wire logic [7:0] laneEnable,
    input wire logic poweredDown,
    // capture status
    output logic rxAccept
);
    int flushCnt;
    // restart on every power-down, since the pipelines hold meaningless samples
    always @(posedge core_clk)
    begin
        if (rst || poweredDown)
            flushCnt <= FLUSH;
        else if (flushCnt > 0)
            flushCnt <= flushCnt - 1;
    end
    // link is up only with lanes driven and the flush over
    assign rxAccept = (flushCnt == 0) && (laneEnable != 8'h00) && !poweredDown;
endmodule

// ==== testbench/serdes_lane_sample_mapper_tb.sv ====
`timescale 1ns/1ns
module serdes_lane_sample_mapper_tb;
    // ****************************************
    // stimulus and design
    // ****************************************
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] mode = 4'h0;
    logic [1:0] variant = 2'h0;
    logic grp = 1'b0;
    logic [1:0] syncH = 2'h0;
    logic [1:0] testSel = 2'h0;
    logic modePd = 1'b0;
    logic pdIn = 1'b0;
    logic sampleValid = 1'b1;
    logic [8:0] sA [16];
    logic [8:0] sB [16];
    logic [8:0] sC [16];
    logic [8:0] sD [16];
    logic [39:0] laneData [8];
    logic [7:0] laneEnable;
    logic [2:0] laneOctets;
    logic syncCrc12, syncFec, altRefused, poweredDown, rxAccept;
    int errorCnt = 0;
    int nChecks = 0;
    always #20 core_clk = ~core_clk;
    slm_lane_mapper i_slm_lane_mapper (.core_clk(core_clk), .rst(rst),
        .laneMappingMode(mode), .variant(variant), .laneGroupSelect(grp),
        .syncHeaderMode(syncH), .serializerTestSelect(testSel), .modePowerDown(modePd),
        .powerDownInput(pdIn), .sampleValid(sampleValid), .sampleA(sA), .sampleB(sB),
        .sampleC(sC), .sampleD(sD), .laneData(laneData), .laneEnable(laneEnable),
        .laneOctets(laneOctets), .syncCrc12(syncCrc12), .syncFec(syncFec),
        .altRefused(altRefused), .poweredDown(poweredDown));
    slm_rx_model #(.FLUSH(6)) i_slm_rx_model (.core_clk(core_clk), .rst(rst),
        .laneEnable(laneEnable), .poweredDown(poweredDown), .rxAccept(rxAccept));
    // ****************************************
    // helpers
    // ****************************************
    // distinct per channel and index, so a swapped lane shows
    function automatic logic [8:0] smp(int ch, int n);
        smp = {ch[1:0], n[3:0], 3'h5};
    endfunction
    function automatic logic [39:0] expLane(logic [3:0] m, int ln);
        logic [8:0] t;
        t = smp(ln / 4, ln % 4);
        case (m)
            slm_pkg::MODE_8BIT_64B: expLane = {t[8:1], 32'h0000_0000};
            slm_pkg::MODE_9BIT_8B10B: expLane = {t, 1'h0, smp(ln / 4, ln % 4 + 4), 1'h0,
                smp(ln / 4, ln % 4 + 8), 1'h0, smp(ln / 4, ln % 4 + 12), 1'h0};
            slm_pkg::MODE_9BIT_QUAD: expLane = {smp(ln / 2, ln % 2), 3'h0,
                smp(ln / 2, ln % 2 + 2), 3'h0, 16'h0000};
            default: expLane = {t, 3'h0, smp(ln / 4, ln % 4 + 4), 3'h0, 16'h0000};
        endcase
    endfunction
    function automatic logic [7:0] expEn(logic [3:0] m, logic [1:0] v);
        if (m == slm_pkg::MODE_9BIT_QUAD)
            expEn = (v == slm_pkg::VAR_SINGLE) ? 8'h03 : (v == slm_pkg::VAR_DUAL) ? 8'h0F : 8'hFF;
        else if (m >= slm_pkg::MODE_8BIT_64B)
            expEn = (v == slm_pkg::VAR_SINGLE) ? 8'h0F : 8'hFF;
        else
            expEn = 8'h00;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs always move 1 ns after the edge
    task automatic step(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic stopTest();
        $display("errors=%0d checks=%0d", errorCnt, nChecks);
        if (errorCnt == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] en, o;
        logic refused, is64;
        logic [39:0] e;
        int sh, cnt;
        for (int n = 0; n < 16; n++)
        begin
            sA[n] = smp(0, n);
            sB[n] = smp(1, n);
            sC[n] = smp(2, n);
            sD[n] = smp(3, n);
        end
        step(8);
        chk(laneEnable, 8'h00);
        chk(laneOctets, 3'h0);
        rst = 1'b0;
        // every mode, variant, lane group and sync header choice
        for (int mi = 12; mi < 16; mi++)
            for (int v = 0; v < 3; v++)
                for (int g = 0; g < 2; g++)
                begin
                    mode = 4'(mi);
                    if (v == 2 && mode != slm_pkg::MODE_9BIT_QUAD)
                        continue;
                    variant = 2'(v);
                    grp = g[0];
                    syncH = 2'(g);
                    en = expEn(mode, variant);
                    refused = grp && en > 8'h0F;
                    is64 = mode != slm_pkg::MODE_9BIT_8B10B;
                    #1;
                    chk(altRefused, refused);
                    chk(syncCrc12, is64 && g == 0);
                    chk(syncFec, is64 && g == 1);
                    step();
                    sh = (grp && !refused) ? 4 : 0;
                    chk(laneEnable, en << sh);
                    chk(laneOctets, (mode == slm_pkg::MODE_8BIT_64B) ? 1 : is64 ? 3 : 5);
                    for (int ln = 0; ln < 8; ln++)
                        if (en[ln])
                            chk(laneData[ln + sh], expLane(mode, ln));
                end
        // power-down from the pin and from the mode setting
        mode = slm_pkg::MODE_9BIT_8B10B;
        variant = slm_pkg::VAR_SINGLE;
        grp = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            modePd = (i == 0);
            pdIn = (i == 1);
            #1;
            chk(poweredDown, 1'b1);
            step();
            chk(laneEnable, 8'h00);
            modePd = 1'b0;
            pdIn = 1'b0;
            step();
            chk(laneEnable, 8'h0F);
            chk(laneData[1], expLane(mode, 1));
            chk(rxAccept, 1'b0);
            cnt = 0;
            while (rxAccept !== 1'b1 && cnt < 20)
            begin
                step();
                cnt++;
            end
            if (cnt == 20)
            begin
                errorCnt++;
                stopTest();
            end
        end
        // test patterns, selected only while the link is down
        pdIn = 1'b1;
        testSel = slm_pkg::TEST_RAMP;
        step();
        pdIn = 1'b0;
        step(2);
        chk(laneEnable, 8'h0F);
        o = laneData[0][39:32];
        step();
        chk(laneData[0][39:32], o + 8'h01);
        chk(laneData[3][39:32], laneData[0][39:32]);
        pdIn = 1'b1;
        testSel = slm_pkg::TEST_CLOCK;
        step();
        pdIn = 1'b0;
        step(2);
        chk(laneEnable, 8'h0F);
        chk($countones(laneData[0][39:24]), 8);
        pdIn = 1'b1;
        testSel = slm_pkg::TEST_OFF;
        step();
        pdIn = 1'b0;
        // reload a live frame first: power-down cleared the lane data
        step();
        // valid low holds the last packed frame
        sampleValid = 1'b0;
        sA[0] = 9'h000;
        step(2);
        chk(laneData[0], expLane(mode, 0));
        sampleValid = 1'b1;
        step();
        e = expLane(mode, 0);
        e[39:31] = 9'h000;
        chk(laneData[0], e);
        // unhandled mode drives no lanes
        mode = 4'h0;
        step();
        chk(laneEnable, 8'h00);
        stopTest();
    end
endmodule
